//--- common/fp_exc_pkg.sv
// Shared constants for the floating-point exception capture block.
`default_nettype none

package fp_exc_pkg;

	// ==========================================================
	// Widths
	localparam int WORD_W = 32;
	localparam int SEL_W = 4;
	localparam int ITERS_W = 3;
	localparam int REGNUM_W = 5;

	// ==========================================================
	// System register selectors used by the privileged moves
	localparam logic [SEL_W-1:0] SEL_STATUS = 4'h8;
	localparam logic [SEL_W-1:0] SEL_EXC_INSTR = 4'h9;
	localparam logic [SEL_W-1:0] SEL_SECOND_INSTR = 4'hA;
	localparam logic [SEL_W-1:0] SEL_IDENT = 4'h0;

	// ==========================================================
	// Instruction word fields
	localparam int COND_HI = 31;
	localparam int COND_LO = 28;
	localparam logic [3:0] COND_ALWAYS = 4'hE;
	localparam int FD_HI = 15;
	localparam int FD_LO = 12;
	localparam int D_BIT = 22;
	localparam int FN_HI = 19;
	localparam int FN_LO = 16;
	localparam int N_BIT = 7;
	localparam int FM_HI = 3;
	localparam int FM_LO = 0;
	localparam int M_BIT = 5;

	// ==========================================================
	// Exception status word layout
	localparam int EXC_MODE_BIT = 31;
	localparam int ENABLE_BIT = 30;
	localparam int SECOND_VALID_BIT = 28;
	localparam int ITERS_HI = 10;
	localparam int ITERS_LO = 8;
	localparam int INPUT_INVALID_BIT = 7;
	localparam int UNDERFLOW_BIT = 3;
	localparam int OVERFLOW_BIT = 2;
	localparam int PRESERVE_BIT = 1;
	localparam int INVALID_OP_BIT = 0;
	localparam logic [WORD_W-1:0] STATUS_RW_MASK = 32'hD000078F;
	localparam logic [ITERS_W-1:0] ITERS_ZERO_CODE = 3'h7;
	localparam logic [ITERS_W-1:0] ITERS_ONE = 3'h1;

	// ==========================================================
	// Reset values
	localparam logic [WORD_W-1:0] STATUS_RESET = 32'h00000000;
	localparam logic [WORD_W-1:0] INSTR_RESET = 32'h00000000;

endpackage : fp_exc_pkg

`default_nettype wire

//--- hdl/instr_capture_reg.sv
// Instruction capture register that forces the always-execute condition on hardware capture; software restores are stored unchanged.
`timescale 1ns/1ps
`default_nettype none

module instr_capture_reg
	import fp_exc_pkg::*;
#(
	parameter int W = WORD_W
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Hardware capture
	input wire logic capture_i,
	input wire logic [W-1:0] capture_word_i,
	// Software restore
	input wire logic sw_wr_i,
	input wire logic [W-1:0] sw_wdata_i,
	// Stored word
	output logic [W-1:0] word_o
);

	logic [W-1:0] word_reg;
	logic [W-1:0] word_next;

	// ==========================================================
	// Next value: a capture wins over a software restore.
	always_comb
	begin
		word_next = word_reg;
		if (capture_i)
		begin
			word_next = capture_word_i;
			word_next[COND_HI:COND_LO] = COND_ALWAYS;
		end
		else if (sw_wr_i)
		begin
			word_next = sw_wdata_i;
		end
	end

	// Register the stored word.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			word_reg <= INSTR_RESET[W-1:0];
		else
			word_reg <= word_next;
	end

	assign word_o = word_reg;

endmodule : instr_capture_reg

`default_nettype wire

//--- hdl/fp_exception_status_capture.sv
// Exception capture and status word logic of the floating-point coprocessor.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Capture exceptional instruction word on bounce.
// - Capture acknowledged unretired instruction as second.
// - Exceptional word condition bits forced always.
// - Vector register fields name first exceptional iteration.
// - Second word unchanged except condition forced.
// - Privileged status moves never undefined, even disabled.
// - Bounce records condition in status word.
// - Underflow flag set when flush-to-zero off.
// - Input invalid on subnormal operand with flush-to-zero off, or NaN operand with default NaN off.
// - Overflow/invalid bounce only when trap enabled.
// - Overflow flag needs enable, no fast mode.
// - Invalid flag needs enable, no fast mode.
// - Exception mode bounces all but moves to selectors eight to ten and privileged ident moves.
// - Enable bit, default disabled.
// - Second valid bit tracks second register.
// - Iteration field reports remaining iterations.
// - Field encodes count minus one, seven zero.
// - Selectors eight, nine, ten; privileged only.
module fp_exception_status_capture
	import fp_exc_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Issued data-processing instruction and first-stage findings
	input wire logic instr_valid_i,
	input wire logic [WORD_W-1:0] instr_word_i,
	input wire logic op_subnormal_i,
	input wire logic op_nan_i,
	input wire logic pot_underflow_i,
	input wire logic pot_overflow_i,
	input wire logic pot_invalid_i,
	// Short-vector rewrite of the exceptional instruction
	input wire logic rewrite_dest_i,
	input wire logic rewrite_srcn_i,
	input wire logic rewrite_srcm_i,
	input wire logic [REGNUM_W-1:0] iter_dest_reg_i,
	input wire logic [REGNUM_W-1:0] iter_srcn_reg_i,
	input wire logic [REGNUM_W-1:0] iter_srcm_reg_i,
	input wire logic [ITERS_W-1:0] iters_left_i,
	// Earlier acknowledged instruction not yet retired
	input wire logic second_valid_i,
	input wire logic [WORD_W-1:0] second_word_i,
	// Mode bits from the user status/control register
	input wire logic flush_to_zero_mode_i,
	input wire logic default_nan_mode_i,
	input wire logic overflow_trap_enable_i,
	input wire logic invalid_trap_enable_i,
	input wire logic fast_mode_i,
	// System register moves
	input wire logic sysreg_valid_i,
	input wire logic sysreg_write_i,
	input wire logic privileged_i,
	input wire logic [SEL_W-1:0] sysreg_sel_i,
	input wire logic [WORD_W-1:0] sysreg_wdata_i,
	// Answers to the core
	output logic bounce_out_o,
	output logic undef_o,
	output logic [WORD_W-1:0] sysreg_rdata_o,
	output logic sysreg_rdata_valid_o,
	// Status seen by the rest of the unit
	output logic unit_enable_o,
	output logic exception_mode_o
);

	// ==========================================================
	// Declarations
	logic [WORD_W-1:0] status_reg;
	logic [WORD_W-1:0] status_next;
	logic bounce_reg;
	logic bounce_next;
	logic undef_reg;
	logic undef_next;
	logic [WORD_W-1:0] rdata_reg;
	logic [WORD_W-1:0] rdata_next;
	logic rvalid_reg;
	logic rvalid_next;
	logic [WORD_W-1:0] exc_instr_word;
	logic [WORD_W-1:0] second_instr_word;
	logic [WORD_W-1:0] exc_capture_word;
	logic our_sel;
	logic exempt_move;
	logic bad_priv_move;
	logic other_req;
	logic in_invalid_c;
	logic underflow_c;
	logic overflow_c;
	logic invalid_op_c;
	logic capture;
	logic capture_second;
	logic wr_exc_instr;
	logic wr_second_instr;

	// Encode remaining iterations: count minus one, and zero as all ones.
	function automatic logic [ITERS_W-1:0] encode_iters(input logic [ITERS_W-1:0] left);
		encode_iters = (left == '0) ? ITERS_ZERO_CODE : left - ITERS_ONE;
	endfunction : encode_iters

	// ==========================================================
	// Request classification
	// selector decode, privilege
	assign our_sel = (sysreg_sel_i == SEL_STATUS) || (sysreg_sel_i == SEL_EXC_INSTR)
		|| (sysreg_sel_i == SEL_SECOND_INSTR);
	assign exempt_move = sysreg_valid_i && privileged_i && (our_sel || (sysreg_sel_i == SEL_IDENT));
	assign bad_priv_move = sysreg_valid_i && !privileged_i && our_sel;
	assign other_req = sysreg_valid_i && !exempt_move && !bad_priv_move;

	// Exception conditions from the first pipeline stage.
	// input invalid terms
	assign in_invalid_c = (op_subnormal_i && !flush_to_zero_mode_i) || (op_nan_i && !default_nan_mode_i);
	assign underflow_c = pot_underflow_i && !flush_to_zero_mode_i;
	assign overflow_c = pot_overflow_i && overflow_trap_enable_i && !fast_mode_i;
	assign invalid_op_c = pot_invalid_i && invalid_trap_enable_i && !fast_mode_i;

	// A capture happens only for an enabled, non-exceptional-mode data instruction.
	assign capture = instr_valid_i && !exempt_move && !bad_priv_move && !status_reg[EXC_MODE_BIT]
		&& status_reg[ENABLE_BIT] && (in_invalid_c || underflow_c || overflow_c || invalid_op_c);
	assign capture_second = capture && second_valid_i;

	// Software restores of the captured words.
	assign wr_exc_instr = exempt_move && sysreg_write_i && (sysreg_sel_i == SEL_EXC_INSTR);
	assign wr_second_instr = exempt_move && sysreg_write_i && (sysreg_sel_i == SEL_SECOND_INSTR);

	// ==========================================================
	// Exceptional instruction rewrite for short vectors
	always_comb
	begin
		exc_capture_word = instr_word_i;
		if (rewrite_dest_i)
		begin
			exc_capture_word[FD_HI:FD_LO] = iter_dest_reg_i[REGNUM_W-1:1];
			exc_capture_word[D_BIT] = iter_dest_reg_i[0];
		end
		if (rewrite_srcn_i)
		begin
			exc_capture_word[FN_HI:FN_LO] = iter_srcn_reg_i[REGNUM_W-1:1];
			exc_capture_word[N_BIT] = iter_srcn_reg_i[0];
		end
		if (rewrite_srcm_i)
		begin
			exc_capture_word[FM_HI:FM_LO] = iter_srcm_reg_i[REGNUM_W-1:1];
			exc_capture_word[M_BIT] = iter_srcm_reg_i[0];
		end
	end

	// ==========================================================
	// Captured instruction registers
	// exceptional word capture
	instr_capture_reg #(
		.W(WORD_W)
	) u_exc_instr (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.capture_i(capture),
		.capture_word_i(exc_capture_word),
		.sw_wr_i(wr_exc_instr),
		.sw_wdata_i(sysreg_wdata_i),
		.word_o(exc_instr_word)
	);

	instr_capture_reg #(
		.W(WORD_W)
	) u_second_instr (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.capture_i(capture_second),
		.capture_word_i(second_word_i),
		.sw_wr_i(wr_second_instr),
		.sw_wdata_i(sysreg_wdata_i),
		.word_o(second_instr_word)
	);

	// ==========================================================
	// Status word, answers and read data
	always_comb
	begin
		status_next = status_reg;
		bounce_next = 1'b0;
		undef_next = 1'b0;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		if (exempt_move)
		begin
			if (sysreg_write_i)
			begin
				if (sysreg_sel_i == SEL_STATUS)
				begin
					status_next = sysreg_wdata_i & STATUS_RW_MASK;
				end
			end
			else
			begin
				rvalid_next = 1'b1;
				unique case (sysreg_sel_i)
					SEL_STATUS: rdata_next = status_reg;
					SEL_EXC_INSTR: rdata_next = exc_instr_word;
					SEL_SECOND_INSTR: rdata_next = second_instr_word;
					default: rdata_next = '0;
				endcase
			end
		end
		else if (bad_priv_move)
		begin
			undef_next = 1'b1;
		end
		else if (instr_valid_i || other_req)
		begin
			if (status_reg[EXC_MODE_BIT])
			begin
				bounce_next = 1'b1;
			end
			else if (!status_reg[ENABLE_BIT])
			begin
				undef_next = 1'b1;
			end
			else if (capture)
			begin
				bounce_next = 1'b1;
				status_next[EXC_MODE_BIT] = 1'b1;
				status_next[INPUT_INVALID_BIT] = in_invalid_c;
				status_next[UNDERFLOW_BIT] = underflow_c;
				status_next[OVERFLOW_BIT] = overflow_c;
				status_next[INVALID_OP_BIT] = invalid_op_c;
				status_next[SECOND_VALID_BIT] = second_valid_i;
				status_next[ITERS_HI:ITERS_LO] = encode_iters(iters_left_i);
			end
		end
	end

	// Register status, answers and read data.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			status_reg <= STATUS_RESET;
			bounce_reg <= 1'b0;
			undef_reg <= 1'b0;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			status_reg <= status_next;
			bounce_reg <= bounce_next;
			undef_reg <= undef_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	// Outputs straight from flip-flops.
	assign bounce_out_o = bounce_reg;
	assign undef_o = undef_reg;
	assign sysreg_rdata_o = rdata_reg;
	assign sysreg_rdata_valid_o = rvalid_reg;
	assign unit_enable_o = status_reg[ENABLE_BIT];
	assign exception_mode_o = status_reg[EXC_MODE_BIT];

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// A capture takes effect and is answered in the next cycle.
	sequence seq_captured;
		bounce_out_o && exception_mode_o;
	endsequence

	sequence seq_data_issue;
		instr_valid_i && !sysreg_valid_i;
	endsequence

	AST_EXC_CAPTURE: assert property (capture |=> seq_captured ##0
		(exc_instr_word[COND_LO-1:0] == $past(exc_capture_word[COND_LO-1:0])))
		else $error("Exceptional instruction not captured.");

	AST_EXC_COND: assert property (capture |=> exc_instr_word[COND_HI:COND_LO] == COND_ALWAYS)
		else $error("Exceptional word condition not forced.");

	AST_VEC_DEST: assert property (capture && rewrite_dest_i |=>
		{exc_instr_word[FD_HI:FD_LO], exc_instr_word[D_BIT]} == $past(iter_dest_reg_i))
		else $error("Vector destination not rewritten.");

	AST_SECOND_WORD: assert property (capture_second |=>
		second_instr_word == {COND_ALWAYS, $past(second_word_i[COND_LO-1:0])})
		else $error("Second instruction wrongly stored.");

	AST_MOVE_NO_TRAP: assert property (exempt_move |=> !undef_o && !bounce_out_o)
		else $error("Privileged move trapped.");

	AST_EX_BOUNCE: assert property (seq_data_issue ##0 exception_mode_o |=> bounce_out_o
		&& $stable(exc_instr_word))
		else $error("Exception mode did not bounce.");

	AST_DISABLED: assert property (seq_data_issue ##0 !unit_enable_o && !exception_mode_o |=>
		undef_o && !bounce_out_o)
		else $error("Disabled unit did not trap.");

	AST_SECOND_VALID: assert property (capture |=> status_reg[SECOND_VALID_BIT] == $past(second_valid_i))
		else $error("Second valid bit wrong.");

	AST_UNDERFLOW: assert property (capture && pot_underflow_i |=>
		status_reg[UNDERFLOW_BIT] == !$past(flush_to_zero_mode_i))
		else $error("Underflow flag wrong.");

	AST_INPUT_INVALID: assert property (capture && op_nan_i && !default_nan_mode_i |=>
		status_reg[INPUT_INVALID_BIT])
		else $error("Input invalid flag missing.");

	AST_OVERFLOW: assert property ($rose(status_reg[OVERFLOW_BIT]) && !$past(exempt_move) |->
		$past(overflow_trap_enable_i && !fast_mode_i && pot_overflow_i))
		else $error("Overflow flag set without cause.");

	AST_INVALID_OP: assert property ($rose(status_reg[INVALID_OP_BIT]) && !$past(exempt_move) |->
		$past(invalid_trap_enable_i && !fast_mode_i && pot_invalid_i))
		else $error("Invalid operation flag set without cause.");

	AST_ITERS: assert property (capture && iters_left_i == '0 |=>
		status_reg[ITERS_HI:ITERS_LO] == ITERS_ZERO_CODE)
		else $error("Zero iteration count wrongly encoded.");

	AST_RESERVED: assert property ((status_reg & ~STATUS_RW_MASK) == '0)
		else $error("Reserved status bits not zero.");

endmodule : fp_exception_status_capture

`default_nettype wire

//--- verification/host_core_model.sv
// Host core model that issues instructions and privileged register moves.
`timescale 1ns/1ps
`default_nettype none

module host_core_model
(
	// Clock
	input wire logic clk_i,
	// Requests to the block
	output logic instr_valid_o,
	output logic move_valid_o,
	output logic move_write_o,
	output logic priv_o,
	output logic [3:0] sel_o,
	output logic [31:0] word_o,
	// Earlier acknowledged instruction
	output logic second_valid_o,
	output logic [31:0] second_word_o
);
	// Nothing is requested at time zero.
	initial
	begin
		instr_valid_o = 1'h0;
		move_valid_o = 1'h0;
		move_write_o = 1'h0;
		priv_o = 1'h0;
		sel_o = 4'h0;
		word_o = 32'h0;
		second_valid_o = 1'h0;
		second_word_o = 32'h0;
	end

	// Issues one data instruction; it stays valid until the next task changes the request lines.
	task automatic instr(input logic [31:0] w, input logic v2, input logic [31:0] w2);
		@(posedge clk_i);
		instr_valid_o <= 1'h1;
		move_valid_o <= 1'h0;
		word_o <= w;
		second_valid_o <= v2;
		second_word_o <= w2;
	endtask : instr

	task automatic move(input logic wr, input logic pr, input logic [3:0] s, input logic [31:0] d);
		@(posedge clk_i);
		instr_valid_o <= 1'h0;
		move_valid_o <= 1'h1;
		move_write_o <= wr;
		priv_o <= pr;
		sel_o <= s;
		word_o <= d;
	endtask : move

	// Releases the request; stale data lines show their inverse.
	task automatic idle();
		@(posedge clk_i);
		instr_valid_o <= 1'h0;
		move_valid_o <= 1'h0;
		word_o <= ~word_o;
		second_word_o <= ~second_word_o;
	endtask : idle

	task automatic clear_exc();
		move(1'h1, 1'h1, 4'h8, 32'h40000000);
	endtask : clear_exc

endmodule : host_core_model

`default_nettype wire

//--- verification/fp_exception_status_capture_tb.sv
// Self-checking testbench for the exception capture block.
`timescale 1ns/1ps
`default_nettype none

module fp_exception_status_capture_tb
	import fp_exc_pkg::*;
;
	// Scoreboard note: bounce, undefined, read valid, read data.
	typedef struct packed {logic b; logic u; logic v; logic [31:0] d;} note_t;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic [4:0] cond = 5'h00;
	logic [4:0] mode = 5'h00;
	logic [2:0] rew = 3'h0;
	logic [14:0] regs = 15'h0000;
	logic [2:0] iters = 3'h0;
	logic iv, mv, mw, mp, s2v, bounce, undef, rvalid, en, exm;
	logic [3:0] sel, fl;
	logic [31:0] word, s2w, rdata, w, w2, r, st;
	logic [31:0] exw = 32'h0;
	logic [31:0] sec = 32'h0;
	note_t q[$];
	note_t n;
	int num_errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	// ==========
	// Clock and instances
	always #20 clk_i = ~clk_i;

	fp_exception_status_capture u_fp_exception_status_capture (
		.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(iv), .instr_word_i(word),
		.op_subnormal_i(cond[4]), .op_nan_i(cond[3]), .pot_underflow_i(cond[2]),
		.pot_overflow_i(cond[1]), .pot_invalid_i(cond[0]), .rewrite_dest_i(rew[2]),
		.rewrite_srcn_i(rew[1]), .rewrite_srcm_i(rew[0]), .iter_dest_reg_i(regs[14:10]),
		.iter_srcn_reg_i(regs[9:5]), .iter_srcm_reg_i(regs[4:0]), .iters_left_i(iters),
		.second_valid_i(s2v), .second_word_i(s2w), .flush_to_zero_mode_i(mode[4]),
		.default_nan_mode_i(mode[3]), .overflow_trap_enable_i(mode[2]),
		.invalid_trap_enable_i(mode[1]), .fast_mode_i(mode[0]), .sysreg_valid_i(mv),
		.sysreg_write_i(mw), .privileged_i(mp), .sysreg_sel_i(sel), .sysreg_wdata_i(word),
		.bounce_out_o(bounce), .undef_o(undef), .sysreg_rdata_o(rdata),
		.sysreg_rdata_valid_o(rvalid), .unit_enable_o(en), .exception_mode_o(exm)
	);

	host_core_model u_host_core_model (
		.clk_i(clk_i), .instr_valid_o(iv), .move_valid_o(mv), .move_write_o(mw), .priv_o(mp),
		.sel_o(sel), .word_o(word), .second_valid_o(s2v), .second_word_o(s2w)
	);

	// ==========
	// Checking tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want)
		begin
			num_errors++;
			$display("ERROR %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : chk

	// Privileged read whose answer is noted for the watcher.
	task automatic rd(input logic [3:0] s, input logic [31:0] want);
		u_host_core_model.move(1'h0, 1'h1, s, $urandom);
		q.push_back({3'h1, want});
	endtask : rd

	task automatic wrap_up();
		$display("errors %0d, comparisons %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	// Matches every answer against the oldest note.
	always @(posedge clk_i)
	begin
		#1;
		if (!rst_i && {bounce, undef, rvalid} !== 3'h0)
		begin
			if (q.size() == 0)
				chk({bounce, undef, rvalid}, 32'h0);
			else
			begin
				n = q.pop_front();
				chk(bounce, n.b);
				chk(undef, n.u);
				chk(rvalid, n.v);
				if (n.v)
					chk(rdata, n.d);
			end
		end
	end

	// Cuts a hang short.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			num_errors++;
			$display("ERROR %0t: run did not finish", $time);
			wrap_up();
		end
	end

	// ==========
	// Main sequence
	initial
	begin
		void'($urandom(3417));
		repeat (10) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		rd(SEL_STATUS, 32'h0);
		rd(SEL_EXC_INSTR, 32'h0);
		rd(SEL_SECOND_INSTR, 32'h0);
		u_host_core_model.instr($urandom, 1'h0, 32'h0);
		q.push_back({3'h2, 32'h0});
		u_host_core_model.move(1'h1, 1'h0, SEL_STATUS, 32'hFFFFFFFF);
		q.push_back({3'h2, 32'h0});
		rd(SEL_STATUS, 32'h0);
		u_host_core_model.move(1'h1, 1'h1, SEL_STATUS, 32'hFFFFFFFF);
		rd(SEL_STATUS, 32'hD000078F);
		u_host_core_model.instr($urandom, 1'h1, $urandom);
		q.push_back({3'h4, 32'h0});
		u_host_core_model.move(1'h0, 1'h1, 4'h1, 32'h0);
		q.push_back({3'h4, 32'h0});
		rd(SEL_IDENT, 32'h0);
		rd(SEL_EXC_INSTR, 32'h0);
		u_host_core_model.clear_exc();
		exw = 32'h13579BDF;
		sec = 32'h2468ACE0;
		u_host_core_model.move(1'h1, 1'h1, SEL_EXC_INSTR, exw);
		u_host_core_model.move(1'h1, 1'h1, SEL_SECOND_INSTR, sec);
		rd(SEL_EXC_INSTR, exw);
		rd(SEL_SECOND_INSTR, sec);
		repeat (40)
		begin
			w = $urandom;
			w2 = $urandom;
			r = $urandom;
			u_host_core_model.instr(w, r[16], w2);
			cond <= r[4:0];
			mode <= r[9:5];
			rew <= r[12:10];
			iters <= r[15:13];
			regs <= r[31:17];
			fl = {(r[4] & !r[9]) | (r[3] & !r[8]), r[2] & !r[9], r[1] & r[7] & !r[5], r[0] & r[6] & !r[5]};
			if (fl != 4'h0)
			begin
				q.push_back({3'h4, 32'h0});
				exw = {4'hE, w[27:0]};
				if (r[12]) {exw[15:12], exw[22]} = r[31:27];
				if (r[11]) {exw[19:16], exw[7]} = r[26:22];
				if (r[10]) {exw[3:0], exw[5]} = r[21:17];
				if (r[16]) sec = {4'hE, w2[27:0]};
				st = {2'h3, 1'h0, r[16], 17'h0, (r[15:13] == 3'h0) ? 3'h7 : r[15:13] - 3'h1,
					fl[3], 3'h0, fl[2:1], 1'h0, fl[0]};
				rd(SEL_STATUS, st);
			end
			else
				rd(SEL_STATUS, 32'h40000000);
			rd(SEL_EXC_INSTR, exw);
			rd(SEL_SECOND_INSTR, sec);
			u_host_core_model.clear_exc();
		end
		u_host_core_model.idle();
		repeat (3) @(posedge clk_i);
		#1;
		chk({exm, en}, 32'h1);
		chk(32'(q.size()), 32'h0);
		wrap_up();
	end

endmodule : fp_exception_status_capture_tb

`default_nettype wire
